// >>> hw/lrgb_regif.sv
// Operation
// - Bytes are eight bits, MSB first.
// - Ninth clock carries ACK; transmitter releases SDA.
// - Addressed device acknowledges every received byte.
// - Device answers slave address 28h only.
// - Write: register byte, then data byte.
// - Write lands at final ACK rising edge.
// - Read returns register selected by prior write.
// - Low register packs red, blue, green LSBs.
// - Upper current bits at 01h, 02h, 03h.
// - Each current code has ten bits.
// - Bit 0 of 05h enables fault output.
// - Delay register fields; bits 5,2 read one.
// - Delay field selects 5 to 35 us.
// - Fault register 07h holds open/short flags.
// - Three suspect falling edges latch a fault.
// - Writing enable 0 clears fault output and flags.
`include "lrgb_regs.svh"
module lrgb_regif (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [2:0] ctrl,
  input wire logic [2:0] open_suspect,
  input wire logic [2:0] short_suspect,
  output logic fault_out,
  output logic [9:0] red_current_code,
  output logic [9:0] green_current_code,
  output logic [9:0] blue_current_code,
  output logic [13:0] red_transition_delay,
  output logic [13:0] green_transition_delay,
  output logic [13:0] blue_transition_delay
);
  import lrgb_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [1:0] ctl_s0;
    logic [1:0] ctl_s1;
    logic [1:0] ctl_s2;
    logic [2:0] ctl_d;
    logic [2:0] osp_s0;
    logic [2:0] osp_s1;
    logic [2:0] ssp_s0;
    logic [2:0] ssp_s1;
    logic scl_d;
    logic sda_d;
    lrgb_state_t st;
    logic [2:0] bitn;
    logic bit_seen;
    logic [7:0] sh;
    logic rw;
    logic have_ptr;
    logic [7:0] ptr;
    logic drive_low;
    logic tx_bit;
    logic [5:0] low;
    logic [7:0] gh;
    logic [7:0] bh;
    logic [7:0] rh;
    logic flt_en;
    logic [5:0] dly;
    logic fault;
  } lrgb_st_t;
  lrgb_st_t s_r;
  lrgb_st_t s_nxt;
  logic [5:0] flags;
  logic [7:0] rd_val;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [2:0] fall_ev;
  logic clr_flt;
  logic [2:0] ctl_sync;

  //////////////////////////////////////////////////////////////////////////
  assign scl_rise = s_r.scl_s[1] && !s_r.scl_d;
  assign scl_fall = !s_r.scl_s[1] && s_r.scl_d;
  assign start_c = s_r.scl_s[1] && s_r.scl_d && s_r.sda_d && !s_r.sda_s[1];
  assign stop_c = s_r.scl_s[1] && s_r.scl_d && !s_r.sda_d && s_r.sda_s[1];
  assign ctl_sync = {s_r.ctl_s2[1], s_r.ctl_s1[1], s_r.ctl_s0[1]};
  assign fall_ev = s_r.ctl_d & ~ctl_sync;
  assign clr_flt = !s_r.flt_en;

  // Fault flag order per channel: 0 green, 1 blue, 2 red; open then short.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_chan
      lrgb_fault_chan u_open (
        .clk(clk),
        .rstn(rstn),
        .ctrl_fall(fall_ev[gi]),
        .suspect(s_r.osp_s1[gi]),
        .clear(clr_flt),
        .flag(flags[2 * gi + 1])
      );
      lrgb_fault_chan u_short (
        .clk(clk),
        .rstn(rstn),
        .ctrl_fall(fall_ev[gi]),
        .suspect(s_r.ssp_s1[gi]),
        .clear(clr_flt),
        .flag(flags[2 * gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    unique case (s_r.ptr)
      `LRGB_OFS_LOW: rd_val = {2'h0, s_r.low};
      `LRGB_OFS_GREEN: rd_val = s_r.gh;
      `LRGB_OFS_BLUE: rd_val = s_r.bh;
      `LRGB_OFS_RED: rd_val = s_r.rh;
      `LRGB_OFS_FLTEN: rd_val = {7'h00, s_r.flt_en};
      `LRGB_OFS_DELAY: rd_val = {s_r.dly[5:4], 1'b1, s_r.dly[3:2], 1'b1,
        s_r.dly[1:0]};
      `LRGB_OFS_FAULT: rd_val = {flags[1:0], 1'b0, flags[3:2], 1'b0,
        flags[5:4]};
      default: rd_val = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.scl_s = {s_r.scl_s[0], scl};
    s_nxt.sda_s = {s_r.sda_s[0], sda_in};
    s_nxt.ctl_s0 = {s_r.ctl_s0[0], ctrl[0]};
    s_nxt.ctl_s1 = {s_r.ctl_s1[0], ctrl[1]};
    s_nxt.ctl_s2 = {s_r.ctl_s2[0], ctrl[2]};
    s_nxt.ctl_d = ctl_sync;
    s_nxt.osp_s0 = open_suspect;
    s_nxt.osp_s1 = s_r.osp_s0;
    s_nxt.ssp_s0 = short_suspect;
    s_nxt.ssp_s1 = s_r.ssp_s0;
    s_nxt.scl_d = s_r.scl_s[1];
    s_nxt.sda_d = s_r.sda_s[1];
    s_nxt.fault = s_r.flt_en && (|flags);
    if (start_c)
    begin
      s_nxt.st = ST_ADDR;
      s_nxt.bitn = 3'h0;
      s_nxt.bit_seen = 1'b0;
      s_nxt.have_ptr = 1'b0;
      s_nxt.drive_low = 1'b0;
    end
    else if (stop_c)
    begin
      s_nxt.st = ST_IDLE;
      s_nxt.drive_low = 1'b0;
    end
    else if (scl_rise)
    begin
      unique case (s_r.st)
        ST_ADDR, ST_WBYTE:
        begin
          s_nxt.sh = {s_r.sh[6:0], s_r.sda_s[1]};
          s_nxt.bitn = s_r.bitn + 3'h1;
          s_nxt.bit_seen = 1'b1;
        end
        ST_WACK:
        begin
          // Data reaches the register only on this edge, mid acknowledge.
          if (s_r.have_ptr)
          begin
            unique case (s_r.ptr)
              `LRGB_OFS_LOW: s_nxt.low = s_r.sh[5:0];
              `LRGB_OFS_GREEN: s_nxt.gh = s_r.sh;
              `LRGB_OFS_BLUE: s_nxt.bh = s_r.sh;
              `LRGB_OFS_RED: s_nxt.rh = s_r.sh;
              `LRGB_OFS_FLTEN: s_nxt.flt_en = s_r.sh[0];
              `LRGB_OFS_DELAY: s_nxt.dly = {s_r.sh[7:6], s_r.sh[4:3],
                s_r.sh[1:0]};
              default: s_nxt.st = s_r.st;
            endcase
          end
        end
        ST_RBYTE:
          s_nxt.bitn = s_r.bitn + 3'h1;
        ST_RACK:
          // Master NACK ends the read; SDA stays released until STOP.
          s_nxt.st = s_r.sda_s[1] ? ST_IDLE : ST_RACK;
        default: s_nxt.st = s_r.st;
      endcase
    end
    else if (scl_fall)
    begin
      unique case (s_r.st)
        ST_ADDR:
          // The fall that ends START carries no bit and must be skipped.
          if (s_r.bitn == 3'h0 && s_r.bit_seen &&
            s_r.sh[7:1] == `LRGB_SLAVE_ADDR)
          begin
            s_nxt.st = ST_AACK;
            s_nxt.rw = s_r.sh[0];
            s_nxt.drive_low = 1'b1;
          end
          else if (s_r.bitn == 3'h0 && s_r.bit_seen)
            s_nxt.st = ST_IDLE;
        ST_AACK:
        begin
          s_nxt.drive_low = 1'b0;
          if (s_r.rw)
          begin
            s_nxt.st = ST_RBYTE;
            s_nxt.sh = {rd_val[6:0], 1'b0};
            s_nxt.tx_bit = rd_val[7];
          end
          else
            s_nxt.st = ST_WBYTE;
        end
        ST_WBYTE:
          if (s_r.bitn == 3'h0)
          begin
            s_nxt.st = ST_WACK;
            s_nxt.drive_low = 1'b1;
            if (!s_r.have_ptr)
            begin
              s_nxt.ptr = s_r.sh;
              s_nxt.have_ptr = 1'b0;
            end
          end
        ST_WACK:
        begin
          s_nxt.drive_low = 1'b0;
          s_nxt.st = ST_WBYTE;
          s_nxt.have_ptr = 1'b1;
        end
        ST_RBYTE:
          if (s_r.bitn == 3'h0)
          begin
            s_nxt.st = ST_RACK;
            s_nxt.tx_bit = 1'b1;
          end
          else
          begin
            s_nxt.tx_bit = s_r.sh[7];
            s_nxt.sh = {s_r.sh[6:0], 1'b0};
          end
        ST_RACK:
        begin
          s_nxt.st = ST_RBYTE;
          s_nxt.sh = {rd_val[6:0], 1'b0};
          s_nxt.tx_bit = rd_val[7];
        end
        default: s_nxt.st = s_r.st;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s_r <= '0;
      s_r.scl_s <= 2'h3;
      s_r.sda_s <= 2'h3;
      s_r.scl_d <= 1'b1;
      s_r.sda_d <= 1'b1;
      s_r.tx_bit <= 1'b1;
      s_r.low <= `LRGB_RST_LOW;
      s_r.gh <= `LRGB_RST_HIGH;
      s_r.bh <= `LRGB_RST_HIGH;
      s_r.rh <= `LRGB_RST_HIGH;
      s_r.flt_en <= 1'b1;
      s_r.dly <= `LRGB_RST_DELAY;
    end
    else
      s_r <= s_nxt;
  end

  //////////////////////////////////////////////////////////////////////////
  // Reading drives data only while transmitting and a zero bit is due.
  always_comb
  begin
    sda_out = 1'b0;
    sda_oe_n = !(s_r.drive_low ||
      (s_r.st == ST_RBYTE && !s_r.tx_bit));
    fault_out = s_r.fault;
    red_current_code = {s_r.rh, s_r.low[5:4]};
    blue_current_code = {s_r.bh, s_r.low[3:2]};
    green_current_code = {s_r.gh, s_r.low[1:0]};
    // Cycle count is 5 us plus 10 us per code step at the core clock.
    red_transition_delay = 14'(`LRGB_DLY_BASE_CYC +
      `LRGB_DLY_STEP_CYC * s_r.dly[5:4]);
    blue_transition_delay = 14'(`LRGB_DLY_BASE_CYC +
      `LRGB_DLY_STEP_CYC * s_r.dly[3:2]);
    green_transition_delay = 14'(`LRGB_DLY_BASE_CYC +
      `LRGB_DLY_STEP_CYC * s_r.dly[1:0]);
  end

  //////////////////////////////////////////////////////////////////////////
  sequence s_wack_rise;
    s_r.st == ST_WACK && s_r.have_ptr && scl_rise && !start_c && !stop_c;
  endsequence
  a_write_lands: assert property (@(posedge clk) disable iff (!rstn)
    s_wack_rise ##0 (s_r.ptr == `LRGB_OFS_RED) |=> s_r.rh == $past(s_r.sh))
    else $error("red register not written at ack edge");
  a_low_top_zero: assert property (@(posedge clk) disable iff (!rstn)
    s_r.ptr == `LRGB_OFS_LOW |-> rd_val[7:6] == 2'h0)
    else $error("low register top bits not zero");
  a_delay_ones: assert property (@(posedge clk) disable iff (!rstn)
    s_r.ptr == `LRGB_OFS_DELAY |-> rd_val[5] && rd_val[2])
    else $error("delay reserved bits not one");
  a_fault_gate: assert property (@(posedge clk) disable iff (!rstn)
    !s_r.flt_en |=> !fault_out)
    else $error("fault output while reporting disabled");
  a_nack_foreign: assert property (@(posedge clk) disable iff (!rstn)
    s_r.st == ST_ADDR && scl_fall && s_r.bitn == 3'h0 && s_r.bit_seen &&
    s_r.sh[7:1] != `LRGB_SLAVE_ADDR && !start_c && !stop_c
    |=> sda_oe_n)
    else $error("foreign address acknowledged");
  a_addr_ack: assert property (@(posedge clk) disable iff (!rstn)
    s_r.st == ST_ADDR && scl_fall && s_r.bitn == 3'h0 && s_r.bit_seen &&
    s_r.sh[7:1] == `LRGB_SLAVE_ADDR && !start_c && !stop_c
    |=> !sda_oe_n && s_r.st == ST_AACK)
    else $error("own address not acknowledged");
  a_byte_ack: assert property (@(posedge clk) disable iff (!rstn)
    s_r.st == ST_WBYTE && scl_fall && s_r.bitn == 3'h0 &&
    !start_c && !stop_c |=> !sda_oe_n)
    else $error("received byte not acknowledged");
  a_rd_flt: assert property (@(posedge clk) disable iff (!rstn)
    s_r.ptr == `LRGB_OFS_FAULT |-> rd_val[5] == 1'b0 && rd_val[2] == 1'b0)
    else $error("fault reserved bits not zero");
endmodule

// >>> hw/lrgb_regs.svh
`ifndef LRGB_REGS_SVH
`define LRGB_REGS_SVH
`define LRGB_SLAVE_ADDR 7'h28
`define LRGB_OFS_LOW 8'h00
`define LRGB_OFS_GREEN 8'h01
`define LRGB_OFS_BLUE 8'h02
`define LRGB_OFS_RED 8'h03
`define LRGB_OFS_FLTEN 8'h05
`define LRGB_OFS_DELAY 8'h06
`define LRGB_OFS_FAULT 8'h07
`define LRGB_RST_LOW 6'h3F
`define LRGB_RST_HIGH 8'hFF
`define LRGB_RST_DELAY 6'h3F
`define LRGB_FAULT_COUNT 2'h3
`define LRGB_DLY_BASE_US 5
`define LRGB_DLY_STEP_US 10
`define LRGB_CLK_MHZ 100
`define LRGB_DLY_BASE_CYC (`LRGB_DLY_BASE_US * `LRGB_CLK_MHZ)
`define LRGB_DLY_STEP_CYC (`LRGB_DLY_STEP_US * `LRGB_CLK_MHZ)
`endif

// >>> hw/lrgb_pkg.sv
package lrgb_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_WBYTE = 3'b011,
    ST_WACK = 3'b100,
    ST_RBYTE = 3'b101,
    ST_RACK = 3'b110
  } lrgb_state_t;
endpackage

// >>> hw/lrgb_fault_chan.sv
`include "lrgb_regs.svh"
module lrgb_fault_chan (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ctrl_fall,
  input wire logic suspect,
  input wire logic clear,
  output logic flag
);
  import lrgb_pkg::*;
  typedef struct packed {
    logic [1:0] cnt;
    logic flag;
  } lrgb_fc_t;
  lrgb_fc_t s_r;
  lrgb_fc_t s_nxt;
  always_comb
  begin
    s_nxt = s_r;
    if (ctrl_fall)
    begin
      if (!suspect)
        s_nxt.cnt = 2'h0;
      else if (s_r.cnt != `LRGB_FAULT_COUNT)
        s_nxt.cnt = s_r.cnt + 2'h1;
      if (suspect && s_r.cnt == `LRGB_FAULT_COUNT - 2'h1)
        s_nxt.flag = 1'b1;
    end
    if (clear)
    begin
      s_nxt.cnt = 2'h0;
      s_nxt.flag = 1'b0;
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rstn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
  assign flag = s_r.flag;
  a_flag_third: assert property (@(posedge clk) disable iff (!rstn)
    ctrl_fall && suspect && s_r.cnt == 2'h2 && !clear |=> flag)
    else $error("fault flag not set on third suspect edge");
  a_flag_clear: assert property (@(posedge clk) disable iff (!rstn)
    clear |=> !flag)
    else $error("fault flag survived clear");
endmodule

// >>> sim/lrgb_i2c_master.sv
module lrgb_i2c_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull,
  output logic res_valid,
  output logic [8:0] res_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // The bus clock stands high between frames and only moves inside them.
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
    res_valid = 1'b0;
    res_data = 9'h000;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One bit slot is eight core cycles, 80 ns, with a long low phase,
  // because the device answers three cycles after the clock falls.
  task automatic bit_io(input logic b, output logic s);
    tick(2);
    sda_pull <= !b;
    tick(3);
    scl <= 1'b1;
    tick(2);
    s = sda;
    tick(1);
    scl <= 1'b0;
  endtask
  task automatic emit(input logic [8:0] r);
    res_data <= r;
    res_valid <= 1'b1;
    tick(1);
    res_valid <= 1'b0;
  endtask
  task automatic start();
    tick(2);
    sda_pull <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda_pull <= 1'b1;
    tick(4);
    scl <= 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sda_pull <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda_pull <= 1'b0;
    tick(8);
  endtask
  task automatic send(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, s);
    emit({1'b1, 7'h00, !s});
  endtask
  task automatic recv(input logic more);
    logic [7:0] d;
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(!more, s);
    emit({1'b0, d});
  endtask
endmodule

// >>> sim/lrgb_regif_tb.sv
module lrgb_regif_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] ctrl;
  logic [2:0] open_suspect;
  logic [2:0] short_suspect;
  logic scl, sda_pull, res_valid, sda_out, sda_oe_n, fault_out, sda;
  logic [8:0] res_data;
  logic [9:0] red_code, green_code, blue_code;
  logic [13:0] red_dly, green_dly, blue_dly;
  logic [8:0] exp_q[$];
  int n_mismatch = 0;
  int num_checks = 0;
  // Pull-up on the data line; any party pulling it low wins.
  assign sda = !(sda_pull || (sda_oe_n === 1'b0 && sda_out === 1'b0));
  always #5 clk = ~clk;
  lrgb_regif dut (.clk(clk), .rstn(rstn), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .ctrl(ctrl),
    .open_suspect(open_suspect), .short_suspect(short_suspect),
    .fault_out(fault_out), .red_current_code(red_code),
    .green_current_code(green_code), .blue_current_code(blue_code),
    .red_transition_delay(red_dly), .green_transition_delay(green_dly),
    .blue_transition_delay(blue_dly));
  lrgb_i2c_master m (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull),
    .res_valid(res_valid), .res_data(res_data));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [47:0] e,
    input logic [47:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  task automatic wrap_up();
    if (exp_q.size() != 0)
      n_mismatch++;
    $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [13:0] dly(input logic [1:0] c);
    return 14'h1F4 + 14'h3E8 * {12'h000, c};
  endfunction
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    repeat (3) exp_q.push_back(9'h101);
    m.start();
    m.send(8'h50);
    m.send(ptr);
    m.send(d);
    m.stop();
  endtask
  task automatic rd(input logic [7:0] ptr, input logic [7:0] v);
    repeat (3) exp_q.push_back(9'h101);
    exp_q.push_back({1'b0, v});
    m.start();
    m.send(8'h50);
    m.send(ptr);
    m.start();
    m.send(8'h51);
    m.recv(1'b0);
    m.stop();
  endtask
  // Control pulses are slow enough for the two-stage synchronisers.
  task automatic falls(input int ch, input int n);
    repeat (n)
    begin
      ctrl[ch] <= 1'b1;
      repeat (6) @(posedge clk);
      ctrl[ch] <= 1'b0;
      repeat (6) @(posedge clk);
    end
    repeat (8) @(posedge clk);
  endtask
  always @(posedge clk)
  begin
    if (res_valid === 1'b1)
    begin
      if (exp_q.size() > 0)
        chk("bus", {39'h0, exp_q.pop_front()}, {39'h0, res_data});
      else
        chk("bus", 48'hFFFF, {39'h0, res_data});
    end
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end
  initial
  begin
    logic [7:0] lo, g, b, r, d, a;
    logic [7:0] rv[8] = '{8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h01, 8'hFF,
      8'h00};
    a = 8'($urandom(32'hEDC247CB));
    ctrl <= 3'h0;
    open_suspect <= 3'h0;
    short_suspect <= 3'h0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk("codes", {18'h0, 30'h3FFFFFFF},
      {18'h0, red_code, green_code, blue_code});
    chk("delays", {6'h0, dly(2'h3), dly(2'h3), dly(2'h3)},
      {6'h0, red_dly, green_dly, blue_dly});
    for (int i = 0; i < 8; i++)
      rd(8'(i), rv[i]);
    a = 8'($urandom_range(127));
    if (a == 8'h28)
      a = 8'h29;
    repeat (2) exp_q.push_back(9'h100);
    m.start();
    m.send({a[6:0], 1'b0});
    m.send(8'h01);
    m.stop();
    for (int i = 0; i < 4; i++)
    begin
      lo = 8'($urandom);
      g = 8'($urandom);
      b = 8'($urandom);
      r = 8'($urandom);
      d = (i == 0) ? 8'h00 : 8'($urandom);
      wr(8'h00, lo);
      wr(8'h01, g);
      wr(8'h02, b);
      wr(8'h03, r);
      wr(8'h06, d);
      chk("codes", {18'h0, r, lo[5:4], g, lo[1:0], b, lo[3:2]},
        {18'h0, red_code, green_code, blue_code});
      chk("delays", {6'h0, dly(d[7:6]), dly(d[1:0]), dly(d[4:3])},
        {6'h0, red_dly, green_dly, blue_dly});
      rd(8'h00, {2'b00, lo[5:0]});
      rd(8'h06, d | 8'h24);
    end
    wr(8'h05, 8'hFE);
    rd(8'h05, 8'h00);
    wr(8'h07, 8'hFF);
    rd(8'h07, 8'h00);
    wr(8'h05, 8'hFF);
    rd(8'h05, 8'h01);
    open_suspect <= 3'b010;
    falls(1, 2);
    chk("fault pin", 48'h0, {47'h0, fault_out});
    falls(1, 1);
    chk("fault pin", 48'h1, {47'h0, fault_out});
    rd(8'h07, 8'h10);
    short_suspect <= 3'b100;
    falls(2, 3);
    rd(8'h07, 8'h11);
    wr(8'h05, 8'h00);
    chk("fault pin", 48'h0, {47'h0, fault_out});
    falls(2, 3);
    rd(8'h07, 8'h00);
    chk("fault pin", 48'h0, {47'h0, fault_out});
    open_suspect <= 3'b000;
    short_suspect <= 3'b001;
    wr(8'h05, 8'h01);
    falls(0, 3);
    chk("fault pin", 48'h1, {47'h0, fault_out});
    rd(8'h07, 8'h40);
    wrap_up();
  end
endmodule
